/* File: inc/ltb_pkg.sv */
/*
  Shared constants and types of the limit-test and binning controller.
  Assumes a single 10 MHz clock; times are converted to cycle counts here.
*/
package ltb_pkg;

  // Widths and counts
  localparam int DATA_W = 32;
  localparam int PAT_W = 4;
  localparam int NLIM = 10;
  localparam int SLOT_W = 7;
  localparam int DELAY_W = 16;
  localparam int LINE4_BIT = 3;

  // Port masks for the two port widths
  localparam logic [PAT_W-1:0] MASK_3BIT = 4'h7;
  localparam logic [PAT_W-1:0] MASK_4BIT = 4'hF;
  localparam logic [PAT_W-1:0] PORT_RESET_PAT = 4'h0;

  // Clock and derived timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int EOT_PULSE_US = 10;
  localparam int EOT_PULSE_CYC = (EOT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EOT_CNT_W = $clog2(EOT_PULSE_CYC + 1);
  localparam int AUTO_CLEAR_TICK_US = 1000;
  localparam int AUTO_CLEAR_TICK_CYC = (AUTO_CLEAR_TICK_US * 1000) / CLK_PERIOD_NS;

  // Source of the reading compared against the limits
  typedef enum logic [1:0] {
    LTB_FEED_CALC = 2'h0,
    LTB_FEED_VOLT = 2'h1,
    LTB_FEED_CURR = 2'h2,
    LTB_FEED_RES = 2'h3
  } ltb_feed_e;

  // Test sequence, Gray along idle -> run -> hold
  typedef enum logic [1:0] {
    LTB_ST_IDLE = 2'h0,
    LTB_ST_RUN = 2'h1,
    LTB_ST_HOLD = 2'h3
  } ltb_state_e;

endpackage

/* File: core/ltb_limit_cmp.sv */
/*
  One numbered limit band: compares a signed reading against its low and
  high limits. Assumes all inputs are on the caller's clock.
*/
`timescale 1ns/100ps
module ltb_limit_cmp #(
  parameter int DATA_W = 32
) (
  input wire logic signed [DATA_W-1:0] value,
  input wire logic signed [DATA_W-1:0] lower,
  input wire logic signed [DATA_W-1:0] upper,
  input wire logic enable,
  output logic lo_fail,
  output logic hi_fail
);

  // A disabled band never reports a failure
  assign lo_fail = enable && (value < lower);
  assign hi_fail = enable && (value > upper);

endmodule

/* File: core/ltb_limit_test.sv */
/*
  Limit-test and binning controller: evaluates each reading, keeps per-test
  results and drives the handler's digital output port.
  Assumes all control inputs come from logic on ref_clk, readings arrive
  with a one-cycle reading_valid strobe, and the handler reads dig_out.
*/
`timescale 1ns/100ps

// Behaviour
// - Host selects which reading feeds comparisons
// - Compliance test fails in or out
// - Lower and upper limit per numbered test
// - Separate lower/upper fail patterns; compliance pattern
// - Per-band pass pattern used in sorting
// - Each test individually enabled or disabled
// - Readable per-test result flag, one fails
// - Global pass pattern; sorting needs bands off
// - Sorting mode fail uses global fail pattern
// - Pass and fail branch targets, slot/next
// - Port update at first failure or end
// - Clear command erases results, clears port
// - Mode selects grading or sorting rules
// - Port width three or four bits
// - Direct pattern write and actual readback
// - Line four is end-of-test or busy
// - Line four active level programmable
// - Auto-clear restores clear pattern after delay
// - Port clear leaves stored results alone
// - Grading drives first failure, else pass
// - Sorting drives first passing band pattern
// - End-of-test pulse on line four, 3-bit
// - Busy function forces three-bit behaviour
module ltb_limit_test #(
  parameter int TICK_CYC = ltb_pkg::AUTO_CLEAR_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ltb_pkg::ltb_feed_e feed_sel,
  input wire logic signed [ltb_pkg::DATA_W-1:0] reading_calc,
  input wire logic signed [ltb_pkg::DATA_W-1:0] reading_volt,
  input wire logic signed [ltb_pkg::DATA_W-1:0] reading_curr,
  input wire logic signed [ltb_pkg::DATA_W-1:0] reading_res,
  input wire logic reading_valid,
  input wire logic sweep_last,
  input wire logic test_start,
  input wire logic in_compliance,
  input wire logic comp_enable,
  input wire logic comp_fail_in,
  input wire logic [ltb_pkg::PAT_W-1:0] comp_fail_pattern,
  input wire logic [ltb_pkg::NLIM-1:0] lim_enable,
  input wire logic [ltb_pkg::NLIM*ltb_pkg::DATA_W-1:0] lim_lower,
  input wire logic [ltb_pkg::NLIM*ltb_pkg::DATA_W-1:0] lim_upper,
  input wire logic [ltb_pkg::NLIM*ltb_pkg::PAT_W-1:0] lim_lo_pattern,
  input wire logic [ltb_pkg::NLIM*ltb_pkg::PAT_W-1:0] lim_hi_pattern,
  input wire logic [ltb_pkg::NLIM*ltb_pkg::PAT_W-1:0] lim_pass_pattern,
  input wire logic [ltb_pkg::PAT_W-1:0] global_pass_pattern,
  input wire logic [ltb_pkg::PAT_W-1:0] global_fail_pattern,
  input wire logic pass_branch_next,
  input wire logic [ltb_pkg::SLOT_W-1:0] pass_branch_slot,
  input wire logic fail_branch_next,
  input wire logic [ltb_pkg::SLOT_W-1:0] fail_branch_slot,
  input wire logic update_at_failure,
  input wire logic sort_mode,
  input wire logic port_width,
  input wire logic line_four_busy,
  input wire logic line_four_polarity,
  input wire logic auto_clear_en,
  input wire logic [ltb_pkg::DELAY_W-1:0] auto_clear_delay,
  input wire logic [ltb_pkg::PAT_W-1:0] clear_pattern,
  input wire logic clear_results,
  input wire logic port_clear,
  input wire logic direct_write,
  input wire logic [ltb_pkg::PAT_W-1:0] direct_pattern,
  output logic [ltb_pkg::NLIM:0] limit_fail,
  output logic [ltb_pkg::PAT_W-1:0] dig_out,
  output logic [ltb_pkg::PAT_W-1:0] port_actual,
  output logic branch_valid,
  output logic branch_next,
  output logic [ltb_pkg::SLOT_W-1:0] branch_slot,
  output logic test_done,
  output logic busy
);
  import ltb_pkg::*;
  localparam int TICK_W = $clog2(TICK_CYC);
  ltb_state_e state_reg;
  logic signed [DATA_W-1:0] reading;
  logic [NLIM-1:0] lo_fail, hi_fail;
  logic comp_fail_now, eval_fail, take, done_now, hold_expire, four_bit, busy_now;
  logic [PAT_W-1:0] eval_pat, eff_mask, final_pat, fail_pat_reg, pat_reg, pat_next;
  logic fail_seen_reg, line4_reg, line4_next, branch_valid_reg, branch_next_reg, test_done_reg;
  logic [NLIM:0] result_reg;
  logic [EOT_CNT_W-1:0] eot_cnt_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [DELAY_W-1:0] delay_cnt_reg;
  logic [SLOT_W-1:0] branch_slot_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Reading selection and comparison

  // Comparison input chosen by the host
  always_comb begin
    unique case (feed_sel)
      LTB_FEED_CALC: reading = reading_calc;
      LTB_FEED_VOLT: reading = reading_volt;
      LTB_FEED_CURR: reading = reading_curr;
      LTB_FEED_RES: reading = reading_res;
    endcase
  end

  // Compliance test, gated by its enable
  assign comp_fail_now = comp_enable && (comp_fail_in ? in_compliance : !in_compliance);

  // One comparator per numbered band
  for (genvar g = 0; g < NLIM; g++) begin : g_band
    ltb_limit_cmp #(.DATA_W(DATA_W)) u_cmp (
      .value(reading),
      .lower(lim_lower[g*DATA_W +: DATA_W]),
      .upper(lim_upper[g*DATA_W +: DATA_W]),
      .enable(lim_enable[g]),
      .lo_fail(lo_fail[g]),
      .hi_fail(hi_fail[g])
    );
  end

  // Verdict and pattern of one reading; lowest band number wins
  always_comb begin
    eval_fail = 1'b0;
    eval_pat = global_pass_pattern;
    if (comp_fail_now) begin
      eval_fail = 1'b1;
      eval_pat = comp_fail_pattern;
    end else if (!sort_mode) begin
      for (int i = 0; i < NLIM; i++) begin
        if (!eval_fail && lo_fail[i]) begin
          eval_fail = 1'b1;
          eval_pat = lim_lo_pattern[i*PAT_W +: PAT_W];
        end else if (!eval_fail && hi_fail[i]) begin
          eval_fail = 1'b1;
          eval_pat = lim_hi_pattern[i*PAT_W +: PAT_W];
        end
      end
    end else if (lim_enable != '0) begin
      // Sorting: fail unless some enabled band holds the reading
      eval_fail = 1'b1;
      eval_pat = global_fail_pattern;
      for (int i = 0; i < NLIM; i++) begin
        if (eval_fail && lim_enable[i] && !lo_fail[i] && !hi_fail[i]) begin
          eval_fail = 1'b0;
          eval_pat = lim_pass_pattern[i*PAT_W +: PAT_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence

  // Busy function shrinks the port so line four is free
  assign four_bit = port_width && !line_four_busy;
  assign eff_mask = four_bit ? MASK_4BIT : MASK_3BIT;
  assign take = (state_reg == LTB_ST_RUN) && reading_valid;
  assign done_now = take && ((eval_fail && update_at_failure) || sweep_last);
  assign final_pat = fail_seen_reg ? fail_pat_reg : eval_pat;
  assign hold_expire = (state_reg == LTB_ST_HOLD) && (delay_cnt_reg >= auto_clear_delay);
  assign busy_now = (state_reg == LTB_ST_RUN);

  // Sequence state; clears abandon a pending auto-clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= LTB_ST_IDLE;
    end else begin
      unique case (state_reg)
        LTB_ST_IDLE: if (test_start) state_reg <= LTB_ST_RUN;
        LTB_ST_RUN: if (done_now) state_reg <= auto_clear_en ? LTB_ST_HOLD : LTB_ST_IDLE;
        LTB_ST_HOLD: begin
          if (test_start) state_reg <= LTB_ST_RUN;
          else if (hold_expire || port_clear || clear_results) state_reg <= LTB_ST_IDLE;
        end
        default: state_reg <= LTB_ST_IDLE;
      endcase
    end
  end
  // First failure of the sweep, kept for end-of-sweep binning
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fail_seen_reg <= 1'b0;
      fail_pat_reg <= PORT_RESET_PAT;
    end else if (test_start && state_reg != LTB_ST_RUN) begin
      fail_seen_reg <= 1'b0;
    end else if (take && eval_fail && !fail_seen_reg) begin
      fail_seen_reg <= 1'b1;
      fail_pat_reg <= eval_pat;
    end
  end

  // Sticky per-test result flags; a new failure beats a clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= '0;
    end else begin
      result_reg <= ((clear_results || (test_start && state_reg != LTB_ST_RUN)) ? '0 : result_reg)
                    | (take ? {lo_fail | hi_fail, comp_fail_now} : '0);
    end
  end

  // Branch target for each reading
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      branch_valid_reg <= 1'b0;
      branch_next_reg <= 1'b0;
      branch_slot_reg <= '0;
    end else begin
      branch_valid_reg <= take;
      if (take) begin
        branch_next_reg <= eval_fail ? fail_branch_next : pass_branch_next;
        branch_slot_reg <= eval_fail ? fail_branch_slot : pass_branch_slot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output port

  // Next port pattern; clears outrank binning, which outranks host writes
  always_comb begin
    pat_next = pat_reg;
    if (clear_results || port_clear) begin
      pat_next = clear_pattern & eff_mask;
    end else if (done_now) begin
      pat_next = final_pat & eff_mask;
    end else if (hold_expire) begin
      pat_next = clear_pattern & eff_mask;
    end else if (direct_write) begin
      pat_next = direct_pattern & eff_mask;
    end
  end
  // Registered port pattern
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pat_reg <= PORT_RESET_PAT;
    end else begin
      pat_reg <= pat_next;
    end
  end
  // Auto-clear delay counted in coarse ticks to keep counters small
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
      delay_cnt_reg <= '0;
    end else if (state_reg != LTB_ST_HOLD) begin
      tick_cnt_reg <= '0;
      delay_cnt_reg <= '0;
    end else if (tick_cnt_reg == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
      delay_cnt_reg <= delay_cnt_reg + DELAY_W'(1);
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  // End-of-test pulse length
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eot_cnt_reg <= '0;
    end else if (done_now) begin
      eot_cnt_reg <= EOT_CNT_W'(EOT_PULSE_CYC);
    end else if (eot_cnt_reg != '0) begin
      eot_cnt_reg <= eot_cnt_reg - EOT_CNT_W'(1);
    end
  end
  // Line four: busy level, end-of-test pulse, or plain pattern bit
  always_comb begin
    if (line_four_busy) begin
      line4_next = line_four_polarity ? busy_now : !busy_now;
    end else if (!port_width) begin
      line4_next = (eot_cnt_reg != '0) ? line_four_polarity : !line_four_polarity;
    end else begin
      // Next value, so a handler never sees bit 3 lag the other lines
      line4_next = pat_next[LINE4_BIT];
    end
  end
  // Registered line four and handshake flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line4_reg <= 1'b0;
      test_done_reg <= 1'b0;
    end else begin
      line4_reg <= line4_next;
      test_done_reg <= done_now;
    end
  end

  assign dig_out = {line4_reg, pat_reg[LINE4_BIT-1:0]};
  assign port_actual = dig_out;
  assign limit_fail = result_reg;
  assign branch_valid = branch_valid_reg;
  assign branch_next = branch_next_reg;
  assign branch_slot = branch_slot_reg;
  assign test_done = test_done_reg;
  assign busy = busy_now;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence eot_start_s;
    done_now && !line_four_busy && !port_width && line_four_polarity;
  endsequence
  sequence cfg_steady_s;
    (!line_four_busy && !port_width && line_four_polarity) [*2];
  endsequence
  comp_result_a: assert property (take && comp_fail_now |=> result_reg[0])
    else $error("compliance failure not recorded");
  clear_res_a: assert property (clear_results && !take && !test_start |=> result_reg == '0)
    else $error("results not erased by clear");
  port_clear_a: assert property (port_clear && !clear_results && !take && !test_start
    |=> $stable(result_reg) && pat_reg == $past(clear_pattern & eff_mask))
    else $error("port clear misbehaved");
  imm_stop_a: assert property (take && eval_fail && update_at_failure |=> state_reg != LTB_ST_RUN)
    else $error("update_at_failure mode did not stop at failure");
  end_cont_a: assert property (take && !sweep_last && !update_at_failure |=> state_reg == LTB_ST_RUN)
    else $error("end mode stopped early");
  bin_pat_a: assert property (done_now && !clear_results && !port_clear
    |=> pat_reg == $past(final_pat & eff_mask) ##1 test_done == 1'b0)
    else $error("wrong binning pattern");
  sort_fail_a: assert property (sort_mode && !comp_fail_now && eval_fail |-> eval_pat == global_fail_pattern)
    else $error("sorting fail pattern wrong");
  eot_pulse_a: assert property (eot_start_s ##0 cfg_steady_s |-> ##1 dig_out[LINE4_BIT])
    else $error("end-of-test pulse missing");
  busy_level_a: assert property (line_four_busy |=> dig_out[LINE4_BIT] == ($past(line_four_polarity) == $past(busy_now)))
    else $error("busy level wrong on line four");
  width_mask_a: assert property (!four_bit && (done_now || direct_write) |=> pat_reg[LINE4_BIT] == 1'b0)
    else $error("pattern not truncated");
  auto_clr_a: assert property (hold_expire && !test_start && !direct_write |=> pat_reg == $past(clear_pattern & eff_mask)
    && state_reg == LTB_ST_IDLE)
    else $error("auto-clear did not restore clear pattern");

endmodule

/* File: verif/ltb_handler_model.sv */
/*
  Handler model on the digital port: latches the bin lines when the
  controller flags end of test.
  Assumes test_done is a one-cycle strobe on ref_clk.
*/
`timescale 1ns/100ps
module ltb_handler_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ltb_pkg::PAT_W-1:0] dig_out,
  input wire logic test_done,
  output logic [ltb_pkg::PAT_W-1:0] bin_seen
);
  import ltb_pkg::*;
  // Bin taken in the done cycle; a slower handler reads the same pattern lines,
  // because they stand until the next clear, direct write or binning
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bin_seen <= 4'h0;
    end else if (test_done) begin
      bin_seen <= dig_out;
    end
  end
endmodule

/* File: verif/ltb_limit_test_bench.sv */
/*
  Self-checking bench of the limit-test controller with a handler model.
  Assumes ltb_pkg and the controller are compiled first.
*/
`timescale 1ns/100ps
module ltb_limit_test_bench;
  import ltb_pkg::*;
  localparam int IN_BOTH = 32'hA0;
  localparam int LO_B1 = 32'h78;
  localparam int HI_B0 = 32'hFA;
  localparam int LO_ALL = 32'h32;
  localparam int OUTSIDE = 32'h3E7;
  logic ref_clk, rstn, reading_valid, sweep_last, test_start, in_compliance;
  logic comp_enable, comp_fail_in, pass_branch_next, fail_branch_next;
  logic update_at_failure, sort_mode, port_width, line_four_busy, line_four_polarity;
  logic auto_clear_en, clear_results, port_clear, direct_write;
  logic branch_valid, branch_next, test_done, busy;
  ltb_feed_e feed_sel;
  logic signed [DATA_W-1:0] reading_calc, reading_volt, reading_curr, reading_res;
  logic [PAT_W-1:0] comp_fail_pattern, global_pass_pattern, global_fail_pattern;
  logic [PAT_W-1:0] clear_pattern, direct_pattern, dig_out, port_actual, msk, bin_seen;
  logic [NLIM-1:0] lim_enable;
  logic [NLIM*DATA_W-1:0] lim_lower, lim_upper;
  logic [NLIM*PAT_W-1:0] lim_lo_pattern, lim_hi_pattern, lim_pass_pattern;
  logic [SLOT_W-1:0] pass_branch_slot, fail_branch_slot, branch_slot;
  logic [DELAY_W-1:0] auto_clear_delay;
  logic [NLIM:0] limit_fail;
  logic [7:0] br;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  // Short auto-clear tick keeps the delay test brief
  ltb_limit_test #(.TICK_CYC(4)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .feed_sel(feed_sel), .reading_calc(reading_calc),
    .reading_volt(reading_volt), .reading_curr(reading_curr), .reading_res(reading_res),
    .reading_valid(reading_valid), .sweep_last(sweep_last), .test_start(test_start),
    .in_compliance(in_compliance), .comp_enable(comp_enable), .comp_fail_in(comp_fail_in),
    .comp_fail_pattern(comp_fail_pattern), .lim_enable(lim_enable), .lim_lower(lim_lower),
    .lim_upper(lim_upper), .lim_lo_pattern(lim_lo_pattern), .lim_hi_pattern(lim_hi_pattern),
    .lim_pass_pattern(lim_pass_pattern), .global_pass_pattern(global_pass_pattern),
    .global_fail_pattern(global_fail_pattern), .pass_branch_next(pass_branch_next),
    .pass_branch_slot(pass_branch_slot), .fail_branch_next(fail_branch_next),
    .fail_branch_slot(fail_branch_slot), .update_at_failure(update_at_failure),
    .sort_mode(sort_mode), .port_width(port_width), .line_four_busy(line_four_busy),
    .line_four_polarity(line_four_polarity), .auto_clear_en(auto_clear_en),
    .auto_clear_delay(auto_clear_delay), .clear_pattern(clear_pattern), .clear_results(clear_results),
    .port_clear(port_clear), .direct_write(direct_write), .direct_pattern(direct_pattern),
    .limit_fail(limit_fail), .dig_out(dig_out), .port_actual(port_actual), .branch_valid(branch_valid),
    .branch_next(branch_next), .branch_slot(branch_slot), .test_done(test_done), .busy(busy));
  ltb_handler_model u_hnd (.ref_clk(ref_clk), .rstn(rstn), .dig_out(dig_out), .test_done(test_done),
    .bin_seen(bin_seen));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task tend(input string s);
    $display("Test %s done, mismatches so far %0d", s, n_mismatch);
  endtask

  // Start strobe for one edge; returns at the second falling edge after RUN begins
  task start();
    test_start = 1;
    @(negedge ref_clk);
    test_start = 0;
    @(negedge ref_clk);
  endtask

  // Other feeds carry a value outside every band, so a wrong feed fails
  task put(input int v, input bit last);
    reading_calc = (feed_sel == LTB_FEED_CALC) ? v : OUTSIDE;
    reading_volt = (feed_sel == LTB_FEED_VOLT) ? v : OUTSIDE;
    reading_curr = (feed_sel == LTB_FEED_CURR) ? v : OUTSIDE;
    reading_res = (feed_sel == LTB_FEED_RES) ? v : OUTSIDE;
    reading_valid = 1;
    sweep_last = last;
    @(negedge ref_clk);
    if (last) reading_valid = 0;
  endtask

  // Bounded wait for the done strobe; keeps the branch target of that cycle
  task done();
    for (int i = 0; i < 30 && test_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({test_done, branch_valid}, 2'h3);
    br = {branch_next, branch_slot};
    @(posedge ref_clk);
    #1;
  endtask

  task run(input int v, input logic [3:0] exp);
    start();
    put(v, 1);
    done();
    chk(bin_seen & msk, exp);
    chk(port_actual & msk, exp);
    @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard; the sequence needs under 1500 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    {rstn, test_start, reading_valid, sweep_last, in_compliance, comp_enable, comp_fail_in} = '0;
    {sort_mode, port_width, line_four_busy, auto_clear_en, clear_results, port_clear, direct_write} = '0;
    {reading_calc, reading_volt, reading_curr, reading_res, direct_pattern} = '0;
    feed_sel = LTB_FEED_VOLT;
    {update_at_failure, line_four_polarity, fail_branch_next, pass_branch_next} = 4'hE;
    // Band 0 spans 100..200, band 1 spans 150..300
    lim_lower = {256'h0, 32'h96, 32'h64};
    lim_upper = {256'h0, 32'h12C, 32'hC8};
    lim_enable = 10'h003;
    lim_lo_pattern = 40'h41;
    lim_hi_pattern = 40'h52;
    lim_pass_pattern = 40'h63;
    {comp_fail_pattern, global_pass_pattern, global_fail_pattern, clear_pattern} = 16'hEFCB;
    pass_branch_slot = 7'h2A;
    fail_branch_slot = 7'h11;
    auto_clear_delay = 16'h0002;
    msk = 4'h7;
    repeat (6) @(negedge ref_clk);
    chk({dig_out, limit_fail}, 15'h0);
    rstn = 1'b1;
    @(negedge ref_clk);
    for (int f = 0; f < 4; f++) begin
      feed_sel = ltb_feed_e'(f);
      run(IN_BOTH, 4'h7);
    end
    chk(br, 8'h2A);
    chk(limit_fail, 11'h000);
    run(LO_B1, 4'h4);
    chk(limit_fail, 11'h004);
    chk(br, 8'h91);
    run(HI_B0, 4'h2);
    chk(limit_fail, 11'h002);
    run(LO_ALL, 4'h1);
    chk(limit_fail, 11'h006);
    lim_enable = 10'h001;
    run(LO_B1, 4'h7);
    lim_enable = 10'h003;
    tend("grading");
    {comp_enable, comp_fail_in, in_compliance} = 3'h7;
    run(IN_BOTH, 4'h6);
    chk(limit_fail, 11'h001);
    comp_fail_in = 1'b0;
    run(IN_BOTH, 4'h7);
    in_compliance = 1'b0;
    run(IN_BOTH, 4'h6);
    comp_enable = 1'b0;
    run(IN_BOTH, 4'h7);
    tend("compliance");
    sort_mode = 1'b1;
    run(IN_BOTH, 4'h3);
    run(HI_B0, 4'h6);
    run(OUTSIDE, 4'h4);
    lim_enable = 10'h000;
    run(OUTSIDE, 4'h7);
    {sort_mode, lim_enable} = 11'h003;
    tend("sorting");
    port_width = 1'b1;
    msk = 4'hF;
    run(IN_BOTH, 4'hF);
    run(LO_B1, 4'h4);
    line_four_busy = 1'b1;
    msk = 4'h7;
    start();
    @(negedge ref_clk);
    chk({busy, dig_out[3]}, 2'h3);
    put(IN_BOTH, 1);
    done();
    @(negedge ref_clk);
    chk({busy, dig_out[3]}, 2'h0);
    chk(dig_out, 4'h7);
    line_four_polarity = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(dig_out[3], 1'b1);
    {port_width, line_four_busy} = 2'h0;
    run(IN_BOTH, 4'h7);
    chk(dig_out[3], 1'b0);
    repeat (110) @(negedge ref_clk);
    chk(dig_out[3], 1'b1);
    line_four_polarity = 1'b1;
    run(IN_BOTH, 4'h7);
    chk(dig_out[3], 1'b1);
    repeat (110) @(negedge ref_clk);
    chk(dig_out[3], 1'b0);
    tend("line four");
    // Sweep to its end: the first failure wins over a later pass
    update_at_failure = 1'b0;
    start();
    put(LO_ALL, 0);
    put(IN_BOTH, 1);
    done();
    chk(bin_seen & msk, 4'h1);
    @(negedge ref_clk);
    update_at_failure = 1'b1;
    start();
    put(LO_B1, 0);
    reading_valid = 1'b0;
    done();
    chk(bin_seen & msk, 4'h4);
    @(negedge ref_clk);
    port_clear = 1'b1;
    @(negedge ref_clk);
    port_clear = 1'b0;
    chk({limit_fail, dig_out & msk}, 15'h043);
    direct_write = 1'b1;
    direct_pattern = 4'h6;
    @(negedge ref_clk);
    direct_write = 1'b0;
    chk(port_actual & msk, 4'h6);
    clear_results = 1'b1;
    @(negedge ref_clk);
    clear_results = 1'b0;
    chk({limit_fail, dig_out & msk}, 15'h003);
    tend("clears");
    auto_clear_en = 1'b1;
    run(IN_BOTH, 4'h7);
    repeat (20) @(negedge ref_clk);
    chk(dig_out & msk, 4'h3);
    tend("auto clear");
    results();
  end
endmodule
